// >>> hdl/io_map_pkg.sv
// constants and types shared by the i/o port map and test controls
package io_map_pkg;
   localparam int PIN_COUNT = 8;
   localparam int FUNC_COUNT = 32;
   localparam int AD_WIDTH = 10;
   localparam int SEL_WIDTH = 6;
   localparam int DIR_BIT = 5;
   localparam int TEST_BITS = 4;
   localparam int PATTERN_BITS = 6;

   // register addresses on the ancillary/control port
   localparam logic [9:0] ADDR_PATTERN = 10'h00d;
   localparam logic [9:0] ADDR_PIN0 = 10'h00f;
   localparam logic [9:0] ADDR_PIN7 = 10'h016;
   localparam logic [9:0] ADDR_TEST_MODE = 10'h055;

   // test-mode field positions and value after reset
   localparam int TM_SCRAMBLER = 0;
   localparam int TM_NRZI = 1;
   localparam int TM_LSB_CLIP = 2;
   localparam int TM_SYNC_DETECT = 3;
   localparam logic [3:0] TEST_MODE_RESET = 4'hf;
   localparam logic [5:0] PATTERN_RESET = 6'h00;

   // pattern select word fields
   localparam int PAT_HD_BIT = 5;
   localparam int PAT_RASTER_HI = 4;
   localparam int PAT_RASTER_LO = 2;

   // function codes on the five low select bits
   localparam logic [4:0] FUNC_EDH_ERR = 5'h04;
   localparam logic [4:0] FUNC_CRC_LUMA_ERR = 5'h10;
   localparam logic [4:0] FUNC_FIELD = 5'h12;
   localparam logic [4:0] FUNC_VERT = 5'h13;
   localparam logic [4:0] FUNC_HORIZ = 5'h14;
   localparam logic [4:0] FUNC_FORMAT4 = 5'h19;
   localparam logic [4:0] FUNC_SELF_CHECK_PASS = 5'h1b;
   localparam logic [4:0] FUNC_LOCK = 5'h1c;
   localparam logic [4:0] FUNC_PATTERN_GEN_ON = 5'h1d;

   // which functions may be read from a pin, which may drive one
   localparam logic [31:0] IN_OK_MASK = 32'h2000_0000;
   localparam logic [31:0] OUT_OK_MASK = 32'hdfff_fffe;

   // default selects, pin 7 in the top six bits
   localparam logic [47:0] PIN_DEFAULTS = {
      6'h3d, 6'h1b, 6'h04, 6'h1c, 6'h19, 6'h14, 6'h13, 6'h12};

   // minimum clk cycles the host leaves between port clock edges
   localparam int HOST_GAP_CYCLES = 8;

   typedef enum logic [0:0] {
      ADDR_PHASE = 1'b0,
      DATA_PHASE = 1'b1
   } phase_type;

   typedef enum logic [1:0] {
      PAT_BLACK = 2'b00,
      PAT_PLL_PATH = 2'b01,
      PAT_EQ_PATH = 2'b10,
      PAT_COLOR_BARS = 2'b11
   } pattern_kind_type;
endpackage : io_map_pkg

// >>> hdl/io_port_map.sv
// multi-function i/o port mapping, test-mode and pattern select registers
`timescale 1ns/10ps
module io_port_map
   import io_map_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic nrst,
   input wire logic soft_reset,
   // ancillary/control port, own clock
   input wire logic aclk,
   input wire logic port_space_select,
   input wire logic port_read_sel,
   input wire logic [AD_WIDTH-1:0] ad_in,
   output logic [AD_WIDTH-1:0] ad_out,
   output logic ad_oe_n,
   // multi-function i/o port
   input wire logic [PIN_COUNT-1:0] io_in,
   output logic [PIN_COUNT-1:0] io_out,
   output logic [PIN_COUNT-1:0] io_oe_n,
   // status functions from the chip, control functions to it
   input wire logic [FUNC_COUNT-1:0] status_in,
   output logic [FUNC_COUNT-1:0] ctrl_bits,
   // test enables
   output logic scrambler_on,
   output logic nrzi_on,
   output logic lsb_clip_on,
   output logic sync_detect_on,
   // pattern selection
   output logic pattern_active,
   output logic pattern_hd,
   output logic [2:0] pattern_raster,
   output logic [1:0] pattern_kind
);

   function automatic logic sel_legal(input logic [SEL_WIDTH-1:0] sel);
      if (sel[DIR_BIT])
         return IN_OK_MASK[sel[4:0]];
      else
         return OUT_OK_MASK[sel[4:0]];
   endfunction : sel_legal

   // link domain
   phase_type phase_reg;
   logic is_read_reg;
   logic [AD_WIDTH-1:0] addr_hold_reg;
   logic [AD_WIDTH-1:0] data_hold_reg;
   logic wr_tog_reg;
   logic rd_tog_reg;

   // system domain
   logic [2:0] wr_sync_reg;
   logic [2:0] rd_sync_reg;
   logic wr_event;
   logic rd_event;
   logic [SEL_WIDTH-1:0] pin_sel_reg [PIN_COUNT];
   logic [TEST_BITS-1:0] test_mode_reg;
   logic [PATTERN_BITS-1:0] pattern_word_reg;
   logic [AD_WIDTH-1:0] rd_data_reg;
   logic [PIN_COUNT-1:0] io_s1_reg;
   logic [PIN_COUNT-1:0] io_s2_reg;
   logic [FUNC_COUNT-1:0] ctrl_reg;
   logic [FUNC_COUNT-1:0] func_value;
   logic [AD_WIDTH-1:0] rd_mux;
   logic [2:0] pin_index;
   logic pin_hit;

   // port clock side: one edge takes the address, the next the data
   always_ff @(posedge aclk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= ADDR_PHASE;
         is_read_reg <= 1'b0;
         addr_hold_reg <= 10'h000;
         data_hold_reg <= 10'h000;
         wr_tog_reg <= 1'b0;
         rd_tog_reg <= 1'b0;
      end else if (port_space_select) begin
         phase_reg <= ADDR_PHASE;
      end else if (phase_reg == ADDR_PHASE) begin
         addr_hold_reg <= ad_in;
         is_read_reg <= port_read_sel;
         phase_reg <= DATA_PHASE;
         if (port_read_sel)
            rd_tog_reg <= ~rd_tog_reg;
      end else begin
         phase_reg <= ADDR_PHASE;
         if (!is_read_reg) begin
            data_hold_reg <= ad_in;
            wr_tog_reg <= ~wr_tog_reg;
         end
      end
   end

   // read data is held still in the system domain long before the data
   // edge, so it is taken here without a synchroniser
   always_ff @(posedge aclk or negedge nrst) begin
      if (!nrst) begin
         ad_out <= 10'h000;
         ad_oe_n <= 1'b1;
      end else if (!port_space_select && phase_reg == DATA_PHASE &&
                   is_read_reg) begin
         ad_out <= rd_data_reg;
         ad_oe_n <= 1'b0;
      end else begin
         ad_oe_n <= 1'b1;
      end
   end

   // toggles cross into clk; address and data are stable by then
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_sync_reg <= 3'h0;
         rd_sync_reg <= 3'h0;
      end else begin
         wr_sync_reg <= {wr_sync_reg[1:0], wr_tog_reg};
         rd_sync_reg <= {rd_sync_reg[1:0], rd_tog_reg};
      end
   end

   assign wr_event = wr_sync_reg[2] ^ wr_sync_reg[1];
   assign rd_event = rd_sync_reg[2] ^ rd_sync_reg[1];
   assign pin_index = addr_hold_reg[2:0] - ADDR_PIN0[2:0];
   assign pin_hit = (addr_hold_reg >= ADDR_PIN0) &&
                    (addr_hold_reg <= ADDR_PIN7);

   // pin select registers; an illegal direction/function pair is ignored
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < PIN_COUNT; i++)
            pin_sel_reg[i] <= PIN_DEFAULTS[i*SEL_WIDTH +: SEL_WIDTH];
      end else if (soft_reset) begin
         for (int i = 0; i < PIN_COUNT; i++)
            pin_sel_reg[i] <= PIN_DEFAULTS[i*SEL_WIDTH +: SEL_WIDTH];
      end else if (wr_event && pin_hit &&
                   sel_legal(data_hold_reg[SEL_WIDTH-1:0])) begin
         pin_sel_reg[pin_index] <= data_hold_reg[SEL_WIDTH-1:0];
      end
   end

   // test-mode: a write sets each enable, a read turns them all back on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         test_mode_reg <= TEST_MODE_RESET;
      else if (soft_reset)
         test_mode_reg <= TEST_MODE_RESET;
      else if (rd_event && addr_hold_reg == ADDR_TEST_MODE)
         test_mode_reg <= TEST_MODE_RESET;
      else if (wr_event && addr_hold_reg == ADDR_TEST_MODE)
         test_mode_reg <= data_hold_reg[TEST_BITS-1:0];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         pattern_word_reg <= PATTERN_RESET;
      else if (soft_reset)
         pattern_word_reg <= PATTERN_RESET;
      else if (wr_event && addr_hold_reg == ADDR_PATTERN)
         pattern_word_reg <= data_hold_reg[PATTERN_BITS-1:0];
   end

   always_comb begin
      rd_mux = 10'h000;
      if (pin_hit)
         rd_mux = {4'h0, pin_sel_reg[pin_index]};
      else if (addr_hold_reg == ADDR_TEST_MODE)
         rd_mux = {6'h00, test_mode_reg};
      else if (addr_hold_reg == ADDR_PATTERN)
         rd_mux = {4'h0, pattern_word_reg};
   end

   // value is captured before the read side effect lands
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         rd_data_reg <= 10'h000;
      else if (rd_event)
         rd_data_reg <= rd_mux;
   end

   // pins are asynchronous to clk
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         io_s1_reg <= 8'h00;
         io_s2_reg <= 8'h00;
      end else begin
         io_s1_reg <= io_in;
         io_s2_reg <= io_s1_reg;
      end
   end

   // control bits come from pins mapped as inputs; if two pins share a
   // function the higher pin wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < PIN_COUNT; i++)
            if (pin_sel_reg[i][DIR_BIT])
               ctrl_reg[pin_sel_reg[i][4:0]] <= io_s2_reg[i];
      end
   end

   assign func_value = (ctrl_reg & IN_OK_MASK) | (status_in & ~IN_OK_MASK);

   generate
      for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               io_out[g] <= 1'b0;
               io_oe_n[g] <= 1'b1;
            end else begin
               io_out[g] <= func_value[pin_sel_reg[g][4:0]];
               io_oe_n[g] <= pin_sel_reg[g][DIR_BIT];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_bits <= 32'h0000_0000;
         scrambler_on <= TEST_MODE_RESET[TM_SCRAMBLER];
         nrzi_on <= TEST_MODE_RESET[TM_NRZI];
         lsb_clip_on <= TEST_MODE_RESET[TM_LSB_CLIP];
         sync_detect_on <= TEST_MODE_RESET[TM_SYNC_DETECT];
      end else begin
         ctrl_bits <= ctrl_reg;
         scrambler_on <= test_mode_reg[TM_SCRAMBLER];
         nrzi_on <= test_mode_reg[TM_NRZI];
         lsb_clip_on <= test_mode_reg[TM_LSB_CLIP];
         sync_detect_on <= test_mode_reg[TM_SYNC_DETECT];
      end
   end

   // pattern outputs follow the word only while the generator is on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pattern_active <= 1'b0;
         pattern_hd <= 1'b0;
         pattern_raster <= 3'h0;
         pattern_kind <= PAT_BLACK;
      end else begin
         pattern_active <= ctrl_reg[FUNC_PATTERN_GEN_ON];
         if (ctrl_reg[FUNC_PATTERN_GEN_ON]) begin
            pattern_hd <= pattern_word_reg[PAT_HD_BIT];
            pattern_raster <=
               pattern_word_reg[PAT_RASTER_HI:PAT_RASTER_LO];
            pattern_kind <= pattern_word_reg[1:0];
         end
      end
   end

   // checks
   property p_pin_write;
      @(posedge clk) disable iff (!nrst)
      (wr_event && !soft_reset && addr_hold_reg == ADDR_PIN0 &&
       sel_legal(data_hold_reg[5:0]))
      |=> pin_sel_reg[0] == $past(data_hold_reg[5:0]);
   endproperty
   a_pin_write: assert property (p_pin_write)
      else $error("pin 0 select not written");

   property p_direction;
      @(posedge clk) disable iff (!nrst)
      $stable(pin_sel_reg[3])
      |=> io_oe_n[3] == $past(pin_sel_reg[3][DIR_BIT]);
   endproperty
   a_direction: assert property (p_direction)
      else $error("pin 3 direction wrong");

   property p_legal;
      @(posedge clk) disable iff (!nrst)
      sel_legal(pin_sel_reg[5]) && sel_legal(pin_sel_reg[0]);
   endproperty
   a_legal: assert property (p_legal)
      else $error("illegal pin mapping held");

   property p_luma_map;
      @(posedge clk) disable iff (!nrst)
      (pin_sel_reg[0] == {1'b0, FUNC_CRC_LUMA_ERR}) [*2]
      |-> io_out[0] == $past(status_in[FUNC_CRC_LUMA_ERR]) && !io_oe_n[0];
   endproperty
   a_luma_map: assert property (p_luma_map)
      else $error("pin 0 not carrying luma error");

   property p_test_write;
      @(posedge clk) disable iff (!nrst)
      (wr_event && !rd_event && !soft_reset &&
       addr_hold_reg == ADDR_TEST_MODE)
      |=> ##1 scrambler_on == $past(data_hold_reg[0], 2) &&
          sync_detect_on == $past(data_hold_reg[3], 2);
   endproperty
   a_test_write: assert property (p_test_write)
      else $error("test-mode write not applied");

   property p_read_sets;
      @(posedge clk) disable iff (!nrst)
      (rd_event && addr_hold_reg == ADDR_TEST_MODE)
      |=> ##1 (scrambler_on && nrzi_on && lsb_clip_on && sync_detect_on);
   endproperty
   a_read_sets: assert property (p_read_sets)
      else $error("test-mode read did not set enables");

   property p_pattern;
      @(posedge clk) disable iff (!nrst)
      ctrl_reg[FUNC_PATTERN_GEN_ON] |=> pattern_active &&
         pattern_hd == $past(pattern_word_reg[5]) &&
         pattern_kind == $past(pattern_word_reg[1:0]);
   endproperty
   a_pattern: assert property (p_pattern)
      else $error("pattern decode wrong");

   property p_soft_reset;
      @(posedge clk) disable iff (!nrst)
      soft_reset |=> pin_sel_reg[7] == PIN_DEFAULTS[47:42] &&
                     pin_sel_reg[4] == PIN_DEFAULTS[29:24];
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("default mapping not restored");

   property p_input_pin;
      @(posedge clk) disable iff (!nrst)
      (pin_sel_reg[7] == PIN_DEFAULTS[47:42]) [*2]
      |-> ctrl_reg[FUNC_PATTERN_GEN_ON] == $past(io_s2_reg[7]);
   endproperty
   a_input_pin: assert property (p_input_pin)
      else $error("input pin not written to its bit");

   c_write: cover property (@(posedge clk) disable iff (!nrst)
      wr_event && pin_hit);
   c_read_test: cover property (@(posedge clk) disable iff (!nrst)
      rd_event && addr_hold_reg == ADDR_TEST_MODE);
   c_pattern: cover property (@(posedge clk) disable iff (!nrst)
      pattern_active && pattern_hd);
   c_drive: cover property (@(posedge aclk) disable iff (!nrst)
      !ad_oe_n);

endmodule : io_port_map

// >>> verif/host_port_model.sv
// host model driving the ancillary/control port
`timescale 1ns/10ps
module host_port_model
   import io_map_pkg::*;
(
   // port clock and selects
   output logic aclk,
   output logic port_space_select,
   output logic port_read_sel,
   // shared address/data bus as seen on the wire
   output logic [AD_WIDTH-1:0] ad_in,
   input wire logic [AD_WIDTH-1:0] ad_out,
   input wire logic ad_oe_n
);
   logic [AD_WIDTH-1:0] drv = 10'h000;
   logic hold = 1'b0;

   initial begin
      aclk = 1'b0;
      port_space_select = 1'b1;
      port_read_sel = 1'b0;
   end

   // released bus shows the inverse, so a stale value never passes
   assign ad_in = !ad_oe_n ? ad_out : (hold ? drv : ~drv);

   // one aclk edge; clock stands still between edges, gap over 80 ns
   task automatic edge_pulse(input logic sel, input logic rd,
         input logic [9:0] v, input logic dr);
      port_space_select = sel;
      port_read_sel = rd;
      drv = v;
      hold = dr;
      #3 aclk = 1'b1;
      #3 aclk = 1'b0;
   endtask : edge_pulse

   task automatic write_reg(input logic [9:0] a, input logic [9:0] d);
      edge_pulse(1'b0, 1'b0, a, 1'b1);
      #90;
      edge_pulse(1'b0, 1'b0, d, 1'b1);
      hold = 1'b0;
      #90;
   endtask : write_reg

   task automatic read_reg(input logic [9:0] a, output logic [9:0] d);
      edge_pulse(1'b0, 1'b1, a, 1'b1);
      #90;
      edge_pulse(1'b0, 1'b1, a, 1'b0);
      #90;
      d = ad_in;
      edge_pulse(1'b1, 1'b0, a, 1'b0);
      #90;
   endtask : read_reg
endmodule : host_port_model

// >>> verif/io_port_map_and_test_controls_bench.sv
// self-checking bench for the i/o port map and test controls
`timescale 1ns/10ps
module io_port_map_and_test_controls_bench
   import io_map_pkg::*;
   ;
   typedef struct {string name; logic [31:0] exp;} note_type;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic soft_reset = 1'b0;
   logic aclk, port_space_select, port_read_sel, ad_oe_n;
   logic [AD_WIDTH-1:0] ad_in, ad_out;
   logic [PIN_COUNT-1:0] io_in = 8'h00;
   logic [PIN_COUNT-1:0] io_out, io_oe_n;
   logic [FUNC_COUNT-1:0] status_in = 32'h0000_0000;
   logic [FUNC_COUNT-1:0] ctrl_bits;
   logic scrambler_on, nrzi_on, lsb_clip_on, sync_detect_on;
   logic pattern_active, pattern_hd;
   logic [2:0] pattern_raster;
   logic [1:0] pattern_kind;
   logic [31:0] seed = 32'hbfbdf8d0;
   logic [5:0] sel_m [PIN_COUNT];
   note_type note_q[$];
   logic [31:0] seen_q[$];
   int mismatches = 0;
   int compares = 0;

   always #5 clk = ~clk;

   io_port_map u_dut (.clk(clk), .nrst(nrst), .soft_reset(soft_reset),
      .aclk(aclk), .port_space_select(port_space_select),
      .port_read_sel(port_read_sel), .ad_in(ad_in), .ad_out(ad_out),
      .ad_oe_n(ad_oe_n), .io_in(io_in), .io_out(io_out),
      .io_oe_n(io_oe_n), .status_in(status_in), .ctrl_bits(ctrl_bits),
      .scrambler_on(scrambler_on), .nrzi_on(nrzi_on),
      .lsb_clip_on(lsb_clip_on), .sync_detect_on(sync_detect_on),
      .pattern_active(pattern_active), .pattern_hd(pattern_hd),
      .pattern_raster(pattern_raster), .pattern_kind(pattern_kind));

   host_port_model u_host (.aclk(aclk),
      .port_space_select(port_space_select),
      .port_read_sel(port_read_sel), .ad_in(ad_in), .ad_out(ad_out),
      .ad_oe_n(ad_oe_n));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s exp %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic expect_val(input string name, input logic [31:0] exp,
         input logic [31:0] seen);
      note_q.push_back('{name, exp});
      seen_q.push_back(seen);
   endtask : expect_val

   // monitor pairs each observed result with the oldest note
   always begin
      wait (seen_q.size() != 0);
      check(note_q[0].name, seen_q.pop_front(), note_q[0].exp);
      note_q.delete(0);
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [9:0] a, input logic [9:0] d);
      u_host.write_reg(a, d);
      tick(2);
   endtask : wr

   task automatic check_pins();
      logic [7:0] oe;
      logic [7:0] out;
      for (int i = 0; i < PIN_COUNT; i++) begin
         oe[i] = sel_m[i][DIR_BIT];
         out[i] = oe[i] ? 1'b0 : status_in[sel_m[i][4:0]];
      end
      expect_val("io_oe_n", {24'h0, oe}, {24'h0, io_oe_n});
      expect_val("io_out", {24'h0, out}, {24'h0, io_out & ~oe});
   endtask : check_pins

   task automatic check_tm(input logic [3:0] e);
      expect_val("test_mode", {28'h0, e}, {28'h0, sync_detect_on,
         lsb_clip_on, nrzi_on, scrambler_on});
   endtask : check_tm

   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done

   task automatic final_report();
      #1;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   // whole run needs about 7 us
   initial begin
      #100000;
      mismatches++;
      final_report();
   end

   initial begin
      logic [9:0] rd;
      logic [5:0] w;
      for (int i = 0; i < PIN_COUNT; i++)
         sel_m[i] = PIN_DEFAULTS[i*6 +: 6];
      repeat (12) @(posedge clk);
      #1;
      nrst = 1'b1;
      status_in = xs();
      tick(3);
      check_pins();
      check_tm(4'hf);
      io_in[7] = 1'b1;
      tick(5);
      expect_val("gen_on", 32'h1, {31'h0, pattern_active});
      io_in[7] = 1'b0;
      tick(5);
      expect_val("ctrl", 32'h0, {31'h0, ctrl_bits[29]});
      done("defaults");
      wr(ADDR_PIN0, 10'h310);
      sel_m[0] = 6'h10;
      status_in = xs();
      tick(2);
      check_pins();
      for (int i = 0; i < PIN_COUNT; i++) begin
         w = 6'(1 + xs() % 28);
         wr(10'(ADDR_PIN0 + i), {4'h0, w});
         sel_m[i] = w;
      end
      status_in = xs();
      tick(2);
      check_pins();
      wr(ADDR_PIN0 + 10'h2, 10'h01d);
      wr(ADDR_PIN0 + 10'h1, 10'h030);
      check_pins();
      wr(ADDR_PIN0 + 10'h3, 10'h03d);
      sel_m[3] = 6'h3d;
      for (int k = 0; k < 2; k++) begin
         io_in = 8'(xs());
         io_in[3] = 1'(k);
         tick(5);
         expect_val("pin_in", 32'(k), {31'h0, pattern_active});
         check_pins();
      end
      u_host.read_reg(ADDR_PIN0 + 10'h3, rd);
      expect_val("pin_rd", 32'h3d, {22'h0, rd});
      // released bus would read back 1ff here, so a missing drive shows
      u_host.read_reg(10'h200, rd);
      expect_val("unmapped", 32'h0, {22'h0, rd});
      expect_val("ad_oe_n", 32'h1, {31'h0, ad_oe_n});
      done("pin map");
      for (int i = 0; i < TEST_BITS; i++) begin
         wr(ADDR_TEST_MODE, 10'(4'hf ^ (4'h1 << i)));
         check_tm(4'hf ^ (4'h1 << i));
      end
      wr(ADDR_TEST_MODE, 10'h005);
      check_tm(4'h5);
      u_host.read_reg(ADDR_TEST_MODE, rd);
      tick(2);
      expect_val("tm_read", 32'h5, {22'h0, rd});
      check_tm(4'hf);
      done("test mode");
      for (int k = 0; k < 8; k++) begin
         w = 6'(xs());
         w[1:0] = 2'(k);
         wr(ADDR_PATTERN, {4'h0, w});
         expect_val("pattern", {26'h0, w}, {26'h0, pattern_hd,
            pattern_raster, pattern_kind});
      end
      done("pattern");
      // generator held on so the cleared pattern word reaches the outputs
      io_in[7] = 1'b1;
      wr(ADDR_TEST_MODE, 10'h000);
      soft_reset = 1'b1;
      tick(2);
      soft_reset = 1'b0;
      tick(3);
      for (int i = 0; i < PIN_COUNT; i++)
         sel_m[i] = PIN_DEFAULTS[i*6 +: 6];
      check_pins();
      check_tm(4'hf);
      expect_val("pat_rst", 32'h0, {26'h0, pattern_hd, pattern_raster,
         pattern_kind});
      done("soft reset");
      tick(2);
      final_report();
   end
endmodule : io_port_map_and_test_controls_bench
